/* File: conv_pkg.sv */
// Overview of operation
// RULE1: Exactly one of eight inputs is selected, picked by the binary value of the latched address.
// RULE2: The address is captured on the rising edge of the address strobe; it must be stable there.
// RULE3: A start rising edge clears the result latch.
// RULE4: Sampling begins at the start edge and lasts 32 clocks before the bit trials.
// RULE5: A new start within the first 64 clocks abandons the conversion and restarts.
// RULE6: An abandoned conversion never delivers its result.
// RULE7: Wiring end-of-conversion back to start gives free-running conversion.
// RULE8: In free-running use, outside logic gives one start pulse after power-up.
// RULE9: A conversion takes from 57 to 74 clocks, start to completion.
// RULE10: End-of-conversion drops within 8 clocks plus 2 us of a start.
// RULE11: Trials run most significant first, weight 128, then 64, 32 and down to the LSB.
// RULE12: A trial that trips sets its result bit and releases the weight, else the weight stays.
// RULE13: One decision per bit, eight in all, then back to sample-then-convert; the code latches the result and idles until the next start.
// RULE14: End-of-conversion stays low while converting and rises once the result is latched.
// RULE15: Data outputs are driven with the result only while output enable is high.
package conv_pkg;

  // --------------------
  // timing
  // --------------------
  localparam int         CLK_PERIOD_NS     = 8;
  localparam int         SAMPLE_CYC        = 32;
  localparam int         TRIAL_CYC         = 4;
  localparam logic [5:0] SAMPLE_LAST       = 6'(SAMPLE_CYC - 1);
  localparam logic [5:0] TRIAL_APPLY       = 6'h00;
  localparam logic [5:0] TRIAL_DECIDE      = 6'(TRIAL_CYC - 1);
  localparam int         CONV_MIN_CYC      = 57;
  localparam int         CONV_MAX_CYC      = 74;
  localparam int         EOC_DROP_BASE_CYC = 8;
  localparam int         EOC_DROP_EXTRA_US = 2;
  localparam int         EOC_DROP_MAX_CYC  = EOC_DROP_BASE_CYC
                                           + (EOC_DROP_EXTRA_US * 1000) / CLK_PERIOD_NS;

  // --------------------
  // converter
  // --------------------
  localparam int         NBITS      = 8;
  localparam int         NCHAN      = 8;
  localparam logic [7:0] MSB_WEIGHT = 8'h80;
  localparam logic [7:0] CHAN0_SEL  = 8'h01;

  // --------------------
  // register map
  // --------------------
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK   = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;
  localparam logic [1:0] REG_CTRL   = 2'h3;
  localparam int         STAT_W     = 2;
  localparam int         ST_DONE    = 0;
  localparam int         ST_ABANDON = 1;
  localparam int         CTRL_START = 0;
  localparam int         RES_CHAN   = 8;
  localparam int         RES_EOC    = 11;
  localparam int         RES_BUSY   = 12;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_TRIAL  = 2'b10,
    ST_LATCH  = 2'b11
  } state_t;

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  // meta_ff feeds q_ff only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

/* File: bit_trial_register.sv */
`timescale 1ns/1ns
module bit_trial_register (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clear_i,
  input  wire logic       apply_i,
  input  wire logic       decide_i,
  input  wire logic       comp_i,
  output logic      [7:0] weight_o,
  output logic      [7:0] result_o,
  output logic      [7:0] active_o
);

  logic [7:0] weight_ff;
  logic [7:0] result_ff;
  logic [7:0] active_ff;
  logic [7:0] nxt_weight;
  logic [7:0] nxt_result;
  logic [7:0] nxt_active;

  // one-hot pointer walks down from the top weight
  assign nxt_active = clear_i  ? conv_pkg::MSB_WEIGHT :   // RULE11
                      decide_i ? (active_ff >> 1) : active_ff;

  for (genvar i = 0; i < conv_pkg::NBITS; i++) begin : g_bit
    logic trip;
    assign trip = decide_i & active_ff[i] & comp_i;
    // tripped trial: result bit set, weight released; else weight stays on
    assign nxt_weight[i] = clear_i ? 1'b0 :
                           (apply_i & active_ff[i]) ? 1'b1 :
                           trip ? 1'b0 : weight_ff[i];        // RULE12
    assign nxt_result[i] = clear_i ? 1'b0 :
                           trip ? 1'b1 : result_ff[i];        // RULE12
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      weight_ff <= 8'h00;
      result_ff <= 8'h00;
      active_ff <= 8'h00;
    end else begin
      weight_ff <= nxt_weight;
      result_ff <= nxt_result;
      active_ff <= nxt_active;
    end
  end

  assign weight_o = weight_ff;
  assign result_o = result_ff;
  assign active_o = active_ff;

endmodule

/* File: adc_sequencer.sv */
`timescale 1ns/1ns
module adc_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic        addr_strobe_i,
  input  wire logic        start_i,
  input  wire logic        comparator_i,
  input  wire logic        out_enable_i,
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  output logic      [7:0]  chan_sel_o,
  output logic             sample_o,
  output logic      [7:0]  trial_weight_o,
  output logic      [7:0]  data_o,
  output logic             data_oe_o,
  output logic             eoc_o,
  output logic             irq_o
);

  // --------------------
  // pin synchronisers
  // --------------------
  logic [6:0] pin_q;
  logic [2:0] addr_s;
  logic       ale_s;
  logic       start_s;
  logic       comp_s;
  logic       oe_s;

  pin_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({addr_i, addr_strobe_i, start_i, comparator_i, out_enable_i}),
    .q_o     (pin_q)
  );

  assign addr_s  = pin_q[6:4];
  assign ale_s   = pin_q[3];
  assign start_s = pin_q[2];
  assign comp_s  = pin_q[1];
  assign oe_s    = pin_q[0];

  // --------------------
  // edge detection
  // --------------------
  logic ale_d_ff;
  logic start_d_ff;
  logic ale_rise;
  logic start_rise;
  logic soft_start;
  logic start_evt;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ale_d_ff   <= 1'b0;
      start_d_ff <= 1'b0;
    end else begin
      ale_d_ff   <= ale_s;
      start_d_ff <= start_s;
    end
  end

  assign ale_rise   = ale_s & ~ale_d_ff;
  assign start_rise = start_s & ~start_d_ff;
  assign soft_start = reg_wr_i & (reg_addr_i == conv_pkg::REG_CTRL)
                    & reg_wdata_i[conv_pkg::CTRL_START];
  // eoc looped to start lands here as an edge: free-running works
  assign start_evt  = start_rise | soft_start;   // RULE7

  // --------------------
  // channel address latch
  // --------------------
  logic [2:0] chan_ff;
  logic [7:0] chan_sel_ff;

  // addr and strobe share the same sync delay, so the pair stays aligned
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chan_ff <= 3'h0;
    end else if (ale_rise) begin
      chan_ff <= addr_s;   // RULE2
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chan_sel_ff <= conv_pkg::CHAN0_SEL;
    end else begin
      chan_sel_ff <= conv_pkg::CHAN0_SEL << chan_ff;   // RULE1
    end
  end

  // --------------------
  // sequencer
  // --------------------
  conv_pkg::state_t state_ff;
  conv_pkg::state_t nxt_state;
  logic [5:0]       cnt_ff;
  logic [5:0]       nxt_cnt;
  logic [7:0]       active;
  logic [7:0]       trial_result;
  logic             busy;
  logic             sample_done;
  logic             phase_apply;
  logic             phase_decide;
  logic             last_decide;

  assign busy         = (state_ff != conv_pkg::ST_IDLE);
  assign sample_done  = (state_ff == conv_pkg::ST_SAMPLE)
                      & (cnt_ff == conv_pkg::SAMPLE_LAST);   // RULE4
  assign phase_apply  = (state_ff == conv_pkg::ST_TRIAL)
                      & (cnt_ff == conv_pkg::TRIAL_APPLY);
  // comparator is read two sync stages after the weight moved
  assign phase_decide = (state_ff == conv_pkg::ST_TRIAL)
                      & (cnt_ff == conv_pkg::TRIAL_DECIDE);
  assign last_decide  = phase_decide & active[0];   // RULE13

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 6'h01;
    if (start_evt) begin
      // any start, even mid-conversion, restarts from sampling
      nxt_state = conv_pkg::ST_SAMPLE;   // RULE5
      nxt_cnt   = 6'h00;
    end else begin
      case (state_ff)
        conv_pkg::ST_IDLE: begin
          nxt_cnt = 6'h00;
        end
        conv_pkg::ST_SAMPLE: begin
          if (sample_done) begin
            nxt_state = conv_pkg::ST_TRIAL;   // RULE4
            nxt_cnt   = 6'h00;
          end
        end
        conv_pkg::ST_TRIAL: begin
          if (phase_decide) begin
            nxt_cnt = 6'h00;
          end
          if (last_decide) begin
            nxt_state = conv_pkg::ST_LATCH;   // RULE13
          end
        end
        conv_pkg::ST_LATCH: begin
          nxt_state = conv_pkg::ST_IDLE;
          nxt_cnt   = 6'h00;
        end
        default: begin
          nxt_state = conv_pkg::ST_IDLE;
          nxt_cnt   = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= conv_pkg::ST_IDLE;
      cnt_ff   <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  bit_trial_register u_trial (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .clear_i  (start_evt),
    .apply_i  (phase_apply),
    .decide_i (phase_decide),
    .comp_i   (comp_s),
    .weight_o (trial_weight_o),
    .result_o (trial_result),
    .active_o (active)
  );

  // --------------------
  // result latch and eoc
  // --------------------
  logic [7:0] result_ff;
  logic       eoc_ff;
  logic       sample_ff;
  logic       latch_now;

  // a start in the latch cycle wins: the old result is dropped
  assign latch_now = (state_ff == conv_pkg::ST_LATCH) & ~start_evt;   // RULE6

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      result_ff <= 8'h00;
      eoc_ff    <= 1'b0;
      sample_ff <= 1'b0;
    end else begin
      if (start_evt) begin
        result_ff <= 8'h00;   // RULE3
        eoc_ff    <= 1'b0;    // RULE10
      end else if (latch_now) begin
        result_ff <= trial_result;
        eoc_ff    <= 1'b1;    // RULE14
      end
      sample_ff <= (nxt_state == conv_pkg::ST_SAMPLE);
    end
  end

  // --------------------
  // three-state data port
  // --------------------
  logic [7:0] data_ff;
  logic       data_oe_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_ff    <= 8'h00;
      data_oe_ff <= 1'b0;
    end else begin
      data_ff    <= oe_s ? result_ff : 8'h00;   // RULE15
      data_oe_ff <= oe_s;                       // RULE15
    end
  end

  // --------------------
  // status, mask, irq
  // --------------------
  logic [1:0]  status_ff;
  logic [1:0]  mask_ff;
  logic [1:0]  stat_set;
  logic [1:0]  stat_clr;
  logic [1:0]  nxt_status;
  logic        irq_ff;
  logic        wr_status;
  logic        wr_mask;

  assign wr_status = reg_wr_i & (reg_addr_i == conv_pkg::REG_STATUS);
  assign wr_mask   = reg_wr_i & (reg_addr_i == conv_pkg::REG_MASK);
  assign stat_set  = {start_evt & busy, latch_now};
  assign stat_clr  = wr_status ? reg_wdata_i[conv_pkg::STAT_W-1:0] : 2'h0;
  // set beats a same-cycle write-one clear
  assign nxt_status = stat_set | (status_ff & ~stat_clr);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      status_ff <= 2'h0;
      mask_ff   <= 2'h0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (wr_mask) begin
        mask_ff <= reg_wdata_i[conv_pkg::STAT_W-1:0];
      end
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // --------------------
  // register read port
  // --------------------
  logic [31:0] rd_mux;
  logic [31:0] res_word;
  logic [31:0] rdata_ff;

  assign res_word = {19'h0, busy, eoc_ff, chan_ff, result_ff};
  assign rd_mux   = (reg_addr_i == conv_pkg::REG_STATUS) ? {30'h0, status_ff} :
                    (reg_addr_i == conv_pkg::REG_MASK)   ? {30'h0, mask_ff}   :
                    (reg_addr_i == conv_pkg::REG_RESULT) ? res_word : 32'h0;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign chan_sel_o  = chan_sel_ff;
  assign sample_o    = sample_ff;
  assign data_o      = data_ff;
  assign data_oe_o   = data_oe_ff;
  assign eoc_o       = eoc_ff;
  assign irq_o       = irq_ff;

  // --------------------
  // checks
  // --------------------
  localparam int EOC_DROP = conv_pkg::EOC_DROP_MAX_CYC;
  localparam int CONV_MIN = conv_pkg::CONV_MIN_CYC;
  localparam int CONV_MAX = conv_pkg::CONV_MAX_CYC;

  logic [7:0] conv_len_ff;
  logic [7:0] samp_len_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || start_evt) begin
      conv_len_ff <= 8'h00;
    end else if (busy && conv_len_ff != 8'hFF) begin
      conv_len_ff <= conv_len_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !sample_ff || start_evt) begin
      samp_len_ff <= 8'h00;
    end else begin
      samp_len_ff <= samp_len_ff + 8'h01;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_to_trial;
    sample_done ##1 ((state_ff == conv_pkg::ST_TRIAL) && !start_evt);
  endsequence

  sequence s_msb_applied;
    ##1 (trial_weight_o == conv_pkg::MSB_WEIGHT);
  endsequence

  property p_chan_sel;
    ale_rise |=> ##1 (chan_sel_o == (conv_pkg::CHAN0_SEL << $past(addr_s, 2)));
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("channel select wrong"); // RULE1

  property p_addr_latch;
    ale_rise |=> (chan_ff == $past(addr_s));
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // RULE2

  property p_clear;
    start_evt |=> (result_ff == 8'h00) && (state_ff == conv_pkg::ST_SAMPLE);
  endproperty
  a_clear: assert property (p_clear) else $error("result not cleared"); // RULE3

  property p_sample_len;
    $fell(sample_ff) && !$past(start_evt) |-> (samp_len_ff == 8'(conv_pkg::SAMPLE_CYC));
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong"); // RULE4

  property p_restart;
    start_evt && busy |=> !eoc_o && (cnt_ff == 6'h00) && status_ff[conv_pkg::ST_ABANDON];
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken"); // RULE5

  property p_msb_first;
    s_to_trial |-> s_msb_applied;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb"); // RULE11

  property p_trip;
    phase_decide && comp_s && !start_evt
      |=> ($countones(trial_result) == $countones($past(trial_result)) + 1)
      && ($countones(trial_weight_o) == $countones($past(trial_weight_o)) - 1);
  endproperty
  a_trip: assert property (p_trip) else $error("tripped trial mishandled"); // RULE12

  property p_conv_len;
    $rose(eoc_ff) |-> (conv_len_ff >= CONV_MIN) && (conv_len_ff <= CONV_MAX);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length out of range"); // RULE9

  property p_eoc_drop;
    start_evt |-> ##[1:EOC_DROP] !eoc_o;
  endproperty
  a_eoc_drop: assert property (p_eoc_drop) else $error("eoc did not drop"); // RULE10

  property p_eoc_busy;
    busy |-> !eoc_o;
  endproperty
  a_eoc_busy: assert property (p_eoc_busy) else $error("eoc high while busy"); // RULE14

  property p_oe;
    !oe_s |=> !data_oe_o && (data_o == 8'h00);
  endproperty
  a_oe: assert property (p_oe) else $error("data driven without enable"); // RULE15

endmodule

/* File: threshold_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// threshold detector holding the selected one of eight inputs
// ----------------------------------------
module threshold_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [63:0] codes_i,
  input  wire logic [7:0]  chan_sel_i,
  input  wire logic        sample_i,
  input  wire logic [7:0]  weight_i,
  output logic             comp_o
);
  logic [7:0] held_ff;
  logic [7:0] pick;
  logic [7:0] cur_w;
  logic       wander_ff;

  // a select that is not one-hot mixes inputs, so the result comes out wrong
  always_comb begin
    pick = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (chan_sel_i[i]) begin
        pick = pick | codes_i[i*8 +: 8];
      end
    end
  end

  // the lowest applied weight is the one on trial
  assign cur_w = weight_i & (~weight_i + 8'h01);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      held_ff   <= 8'h00;
      wander_ff <= 1'b0;
    end else begin
      if (sample_i) begin
        held_ff <= pick;
      end
      wander_ff <= ~wander_ff;
    end
  end

  // detector answers at once: the two sync stages inside use up the settle time
  // no weight applied: output wanders so a stray sample is noticed
  assign comp_o = (weight_i == 8'h00) ? wander_ff : |(held_ff & cur_w);
endmodule

/* File: mux_adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ns
module mux_adc_conversion_sequencer_tb;
  logic        clk;
  logic        rst_b;
  logic [2:0]  addr;
  logic        addr_strobe;
  logic        start_drv;
  logic        free_mode;
  logic        out_enable;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] rdata;
  logic [7:0]  chan_sel;
  logic        sample;
  logic [7:0]  trial_weight;
  logic [7:0]  data;
  logic        data_oe;
  logic        eoc;
  logic        irq;
  logic        comp;
  logic [31:0] rd;
  wire  [7:0]  data_pins;
  wire         start_pin;
  int          fail_count;
  int          total_checks;
  int          cycle_count;
  // channel n holds code bits [8n+7:8n]
  localparam logic [63:0] CODES = 64'hC37E01805AA500FF;

  assign data_pins = data_oe ? data : 8'hZZ;
  assign start_pin = free_mode ? eoc : start_drv;

  adc_sequencer dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .addr_strobe_i(addr_strobe),
    .start_i(start_pin), .comparator_i(comp), .out_enable_i(out_enable),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .chan_sel_o(chan_sel), .sample_o(sample),
    .trial_weight_o(trial_weight), .data_o(data), .data_oe_o(data_oe), .eoc_o(eoc),
    .irq_o(irq));

  threshold_model far_u (
    .clk_i(clk), .rst_b_i(rst_b), .codes_i(CODES), .chan_sel_i(chan_sel),
    .sample_i(sample), .weight_i(trial_weight), .comp_o(comp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs under 2000 cycles
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // address held well clear of the strobe edge, then disturbed
  task automatic select_chan(input logic [2:0] ch);
    @(posedge clk);
    addr <= ch;
    tick(3);
    addr_strobe <= 1'b1;
    tick(3);
    addr_strobe <= 1'b0;
    tick(3);
    addr <= ~ch;
    tick(4);
    check("chan_sel", 8'h01 << ch, chan_sel);
  endtask

  // one pin start, timed from the edge that raises the pin
  task automatic run_conv(input logic [2:0] ch, input bit fresh);
    int         n;
    int         fall;
    int         rise;
    int         samp;
    int         bad;
    logic [7:0] fw;
    n    = 0;
    fall = -1;
    rise = -1;
    samp = 0;
    bad  = 0;
    fw   = 8'h00;
    @(posedge clk);
    start_drv <= 1'b1;
    while (rise < 0 && n < 300) begin
      @(posedge clk);
      if (n == 3) start_drv <= 1'b0;
      #1 n++;
      if (fall < 0 && eoc === 1'b0) fall = n;
      if (sample === 1'b1) samp++;
      if (sample === 1'b1 && eoc !== 1'b0) bad++;
      if (n > 3 && fw == 8'h00 && trial_weight !== 8'h00) fw = trial_weight;
      if (n == 20) check("data while busy", 8'h00, data_pins);
      if (fall >= 0 && n > 4 && eoc === 1'b1) rise = n;
    end
    check("eoc drop", 1, fall >= 1 && fall <= conv_pkg::EOC_DROP_MAX_CYC);
    check("conv length", 1, rise >= conv_pkg::CONV_MIN_CYC && rise <= conv_pkg::CONV_MAX_CYC);
    check("eoc while busy", 0, bad);
    check("first weight", conv_pkg::MSB_WEIGHT, fw);
    if (fresh) check("sample cycles", conv_pkg::SAMPLE_CYC, samp);
    tick(4);
    check("data", CODES[ch*8 +: 8], data_pins);
    reg_read(conv_pkg::REG_RESULT, rd);
    check("result word", {19'h0, 2'b01, ch, CODES[ch*8 +: 8]}, rd);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_channels();
    for (int c = 0; c < 8; c++) begin
      select_chan(3'(c));
      run_conv(3'(c), 1'b1);
    end
  endtask

  // second start well inside 64 cycles; old result must never appear
  task automatic test_restart();
    reg_write(conv_pkg::REG_STATUS, 32'h3);
    reg_write(conv_pkg::REG_MASK, 32'h2);
    select_chan(3'h0);
    @(posedge clk);
    start_drv <= 1'b1;
    tick(3);
    start_drv <= 1'b0;
    tick(4);
    select_chan(3'h1);
    run_conv(3'h1, 1'b0);
    check("irq abandon", 1'b1, irq);
    reg_read(conv_pkg::REG_STATUS, rd);
    check("status after restart", 32'h3, rd);
    reg_write(conv_pkg::REG_STATUS, 32'h3);
    tick(2);
    check("irq cleared", 1'b0, irq);
  endtask

  task automatic test_irq();
    reg_write(conv_pkg::REG_MASK, 32'h1);
    select_chan(3'h2);
    run_conv(3'h2, 1'b1);
    check("irq done", 1'b1, irq);
    reg_write(conv_pkg::REG_STATUS, 32'h1);
    tick(2);
    check("irq w1c", 1'b0, irq);
    reg_write(conv_pkg::REG_MASK, 32'h0);
    run_conv(3'h2, 1'b1);
    check("irq masked", 1'b0, irq);
    reg_read(conv_pkg::REG_STATUS, rd);
    check("status done", 32'h1, rd);
    reg_read(conv_pkg::REG_MASK, rd);
    check("mask", 32'h0, rd);
    reg_read(conv_pkg::REG_CTRL, rd);
    check("ctrl reads", 32'h0, rd);
    reg_write(conv_pkg::REG_CTRL, 32'h1);
    tick(2);
    check("soft start eoc", 1'b0, eoc);
    tick(75);
    check("soft start data", CODES[23:16], data_pins);
    check("soft start eoc end", 1'b1, eoc);
    reg_write(conv_pkg::REG_STATUS, 32'h3);
  endtask

  // end-of-conversion looped to start; one kick first
  task automatic test_free_run();
    int rises;
    int limit;
    logic last;
    rises = 0;
    limit = 0;
    run_conv(3'h2, 1'b1);
    free_mode = 1'b1;
    last = eoc;
    repeat (300) begin
      @(posedge clk);
      #1 if (eoc === 1'b1 && last === 1'b0) rises++;
      last = eoc;
    end
    check("free run count", 1, rises >= 4 && rises <= 6);
    @(posedge clk);
    free_mode <= 1'b0;
    while (eoc !== 1'b1 && limit < 200) begin
      @(posedge clk);
      limit++;
    end
    check("free run end", 1, limit < 200);
    tick(4);
    check("free run data", CODES[23:16], data_pins);
  endtask

  task automatic test_oe();
    @(posedge clk);
    out_enable <= 1'b0;
    tick(5);
    check("oe off", 1'b0, data_oe);
    check("pins off", 8'hZZ, data_pins);
    @(posedge clk);
    out_enable <= 1'b1;
    tick(5);
    check("pins on", CODES[23:16], data_pins);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b       = 1'b0;
    addr        = 3'h0;
    addr_strobe = 1'b0;
    start_drv   = 1'b0;
    free_mode   = 1'b0;
    out_enable  = 1'b0;
    reg_addr    = 2'h0;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    fail_count  = 0;
    total_checks = 0;
    cycle_count = 0;
    tick(16);
    rst_b <= 1'b1;
    tick(3);
    check("reset chan_sel", conv_pkg::CHAN0_SEL, chan_sel);
    check("reset eoc", 1'b0, eoc);
    check("reset irq", 1'b0, irq);
    check("reset oe", 1'b0, data_oe);
    out_enable <= 1'b1;
    test_channels();
    test_restart();
    test_irq();
    test_free_run();
    test_oe();
    give_verdict();
  end
endmodule
